// ---- design/drs_pkg.sv ----
package drs_pkg;

  // target families
  localparam logic FAM_LEGACY = 1'b0;
  localparam logic FAM_MPROF  = 1'b1;

  // strategy codes
  localparam logic [3:0] M_NORMAL    = 4'h0;
  localparam logic [3:0] M_CORE      = 4'h1;
  localparam logic [3:0] M_PIN       = 4'h2;
  localparam logic [3:0] L_HW_BP0    = 4'h1;
  localparam logic [3:0] L_SW_ROUT   = 4'h2;
  localparam logic [3:0] L_NONE      = 4'h3;
  localparam logic [3:0] L_HW_WP     = 4'h4;
  localparam logic [3:0] L_HW_REQ    = 4'h5;
  localparam logic [3:0] L_SW_REGS   = 4'h6;
  localparam logic [3:0] L_PERIPH    = 4'h8;
  localparam logic [3:0] L_REMAP     = 4'h9;

  // target debug operations issued to the access engine
  typedef enum logic [3:0] {
    OP_SET_CATCH   = 4'b0000,
    OP_CLR_CATCH   = 4'b0001,
    OP_SYS_RESET   = 4'b0010,
    OP_CORE_RESET  = 4'b0011,
    OP_POLL_STICKY = 4'b0100,
    OP_HALT        = 4'b0101,
    OP_LOAD_ROUT   = 4'b0110,
    OP_BP_ZERO     = 4'b0111,
    OP_RUN_ROUT    = 4'b1000,
    OP_WP_HALT     = 4'b1001,
    OP_REQ_HALT    = 4'b1010,
    OP_LOAD_REGS   = 4'b1011,
    OP_RSTC_WRITE  = 4'b1100,
    OP_MAP_FLASH   = 4'b1101
  } drs_op_e;

  // register reset values (the PC and GPR ones unused), reset controller command and breakpoint address used by the strategies
  localparam logic [31:0] PC_RESET_VAL   = 32'h0000_0000;
  localparam logic [31:0] CURRENT_PROGRAM_STATUS_RESET_VAL = 32'h0000_00D3;
  localparam logic [31:0] SAVED_PROGRAM_STATUS_RESET_VAL = 32'h0000_0010;
  localparam logic [31:0] GPR_RESET_VAL  = 32'h0000_0000;
  localparam logic [31:0] RSTC_CMD_VAL   = 32'h0000_0004;
  localparam logic [31:0] BP_ADDR_VAL    = 32'h0000_0000;

  // reset pin pulse and pin-low check timing
  localparam int          CLK_MHZ       = 40;
  localparam int          PULSE_NS      = 1000;
  localparam int          PULSE_CYC_I   = (PULSE_NS * CLK_MHZ) / 1000;
  localparam logic [7:0]  PULSE_CYC     = PULSE_CYC_I[7:0];
  localparam logic [7:0]  CNT_ZERO      = 8'h00;
  localparam logic [7:0]  CNT_ONE       = 8'h01;

  // request from the host side
  typedef struct packed {
    logic       start;
    logic       family;
    logic [3:0] code;
  } drs_req_s;

  // operation toward the target access engine
  typedef struct packed {
    logic        valid;
    drs_op_e     op;
    logic [31:0] data;
  } drs_op_s;

  // completion answer from the target access engine
  typedef struct packed {
    logic done;
    logic ok;
    logic sticky;
    logic halted;
  } drs_ack_s;

endpackage

// ---- design/drs_sequencer.sv ----
// Function
// (R1) m-profile code 0 default, system reset sequence
// (R2) set halt catch before system reset
// (R3) system reset request resets core, peripherals
// (R4) poll sticky reset: first high, then low
// (R5) clear halt catch as last step
// (R6) code 1: core-only reset, catch, poll
// (R7) code 2: catch, pin low, fail if undriven
// (R8) host never selects deprecated codes 3-10
// (R9) every m-profile strategy ends halted
// (R10) legacy 2: halt, load, bp0, execute
// (R11) legacy 3: no action at all
// (R12) legacy 4: pin pulse, retry watchpoint halt
// (R13) legacy 5: pin pulse, hold halt request
// (R14) legacy 6: load register reset values only
// (R15) host never selects reserved legacy 7
// (R16) legacy 8: write 4 to reset controller
// (R17) legacy 9: strategy 1 then map flash
// (R18) legacy 1: breakpoint at 0, then pin
// (R19) bad code: no access, report error
`timescale 1ns/1ps
module drs_sequencer
  import drs_pkg::*;
(
  input  wire logic     clock_in,
  input  wire logic     rst_b_in,
  input  wire drs_req_s req_in,
  input  wire drs_ack_s ack_in,
  input  wire logic     tgt_reset_line_in,
  output drs_op_s       op_out,
  output logic          reset_pin_b_out,
  output logic          busy_out,
  output logic          done_out,
  output logic          error_out
);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_ISSUE  = 4'b0001,
    ST_WAIT   = 4'b0010,
    ST_PULSE  = 4'b0011,
    ST_FINISH = 4'b0100
  } drs_state_e;

  // step kinds inside a strategy program
  typedef enum logic [2:0] {
    K_OP     = 3'b000,
    K_POLLHI = 3'b001,
    K_POLLLO = 3'b010,
    K_PIN    = 3'b011,
    K_RETRY  = 3'b100,
    K_END    = 3'b101
  } drs_kind_e;

  drs_state_e  state, next_state;
  logic [2:0]  step, next_step;
  logic        fam, next_fam;
  logic [3:0]  code, next_code;
  logic        fail, next_fail;
  logic [7:0]  cnt, next_cnt;
  logic        pin_seen, next_pin_seen;
  drs_op_s     op, next_op;
  logic        pin_b, next_pin_b;
  logic        busy, next_busy;
  logic        done, next_done;
  logic        err, next_err;
  logic        line_s1, line_s2;

  drs_kind_e   kind;
  drs_op_e     kop;
  logic [31:0] kdata;
  logic        supported;

  // reset line comes from the target pin: two flops before use
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      line_s1 <= 1'b1;
      line_s2 <= 1'b1;
    end
    else
    begin
      line_s1 <= tgt_reset_line_in;
      line_s2 <= line_s1;
    end
  end

  // which codes this sequencer runs; everything else is refused
  always_comb
  begin
    if (req_in.family == FAM_MPROF)
      supported = req_in.code inside {M_NORMAL, M_CORE, M_PIN}; // R8
    else
      supported = req_in.code inside {L_HW_BP0, L_SW_ROUT, L_NONE, L_HW_WP, L_HW_REQ,
                                      L_SW_REGS, L_PERIPH, L_REMAP}; // R15
  end

  // strategy programs: each step of the selected code as kind, op and data
  always_comb
  begin
    kind  = K_END;
    kop   = OP_SET_CATCH;
    kdata = '0;
    if (fam == FAM_MPROF)
    begin
      // m-profile codes 0 and 1 share catch set, reset, poll, catch clear; code 2 pulses the pin instead of reset and poll
      case (step)
        3'd0: begin kind = K_OP; kop = OP_SET_CATCH; end // R2
        3'd1:
        begin
          if (code == M_PIN)
            kind = K_PIN; // R7
          else
          begin
            kind = K_OP;
            kop  = (code == M_CORE) ? OP_CORE_RESET : OP_SYS_RESET; // R1 R3 R6
          end
        end
        3'd2: // pin strategy clears the catch here; poll kinds ignore kop
        begin
          kind = (code == M_PIN) ? K_OP : K_POLLHI; // R4
          kop  = OP_CLR_CATCH; // R9
        end
        3'd3: kind = (code == M_PIN) ? K_END : K_POLLLO; // R4
        3'd4: begin kind = K_OP; kop = OP_CLR_CATCH; end // R5
        default: kind = K_END;
      endcase
    end
    else
    begin
      case (code)
        L_HW_BP0, L_REMAP:
        begin
          case (step)
            3'd0: begin kind = K_OP; kop = OP_BP_ZERO; kdata = BP_ADDR_VAL; end // R18
            3'd1: kind = K_PIN; // R18
            3'd2:
            begin
              kind = (code == L_REMAP) ? K_OP : K_END;
              kop  = OP_MAP_FLASH; // R17
            end
            default: kind = K_END;
          endcase
        end
        L_SW_ROUT:
        begin
          case (step) // R10
            3'd0: begin kind = K_OP; kop = OP_HALT; end
            3'd1: begin kind = K_OP; kop = OP_LOAD_ROUT; end
            3'd2: begin kind = K_OP; kop = OP_BP_ZERO; kdata = BP_ADDR_VAL; end
            3'd3: begin kind = K_OP; kop = OP_RUN_ROUT; end
            default: kind = K_END;
          endcase
        end
        L_HW_WP, L_HW_REQ:
        begin
          case (step)
            3'd0: kind = K_PIN; // R12 R13
            3'd1:
            begin
              kind = K_RETRY;
              kop  = (code == L_HW_WP) ? OP_WP_HALT : OP_REQ_HALT; // R12 R13
            end
            default: kind = K_END;
          endcase
        end
        L_SW_REGS:
        begin
          if (step == 3'd0)
          begin
            kind  = K_OP;
            kop   = OP_LOAD_REGS; // R14
            kdata = {CURRENT_PROGRAM_STATUS_RESET_VAL[15:0], SAVED_PROGRAM_STATUS_RESET_VAL[15:0]};
          end
        end
        L_PERIPH:
        begin
          if (step == 3'd0)
          begin
            kind  = K_OP;
            kop   = OP_RSTC_WRITE; // R16
            kdata = RSTC_CMD_VAL;
          end
        end
        default: kind = K_END; // R11
      endcase
    end
  end

  // sequencer next-state logic
  always_comb
  begin
    next_state    = state;
    next_step     = step;
    next_fam      = fam;
    next_code     = code;
    next_fail     = fail;
    next_cnt      = cnt;
    next_pin_seen = pin_seen;
    next_op       = op;
    next_pin_b    = pin_b;
    next_busy     = busy;
    next_done     = 1'b0;
    next_err      = err;
    next_op.valid = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (req_in.start)
        begin
          if (!supported)
          begin
            next_done = 1'b1; // R19
            next_err  = 1'b1;
          end
          else
          begin
            next_fam   = req_in.family;
            next_code  = req_in.code;
            next_step  = 3'd0;
            next_fail  = 1'b0;
            next_err   = 1'b0;
            next_busy  = 1'b1;
            next_state = ST_ISSUE;
          end
        end
      end
      ST_ISSUE:
      begin
        if (kind == K_END)
          next_state = ST_FINISH;
        else if (kind == K_PIN)
        begin
          next_pin_b    = 1'b0;
          next_cnt      = PULSE_CYC;
          next_pin_seen = 1'b0;
          next_state    = ST_PULSE;
        end
        else
        begin
          next_op.valid = 1'b1;
          next_op.op    = (kind == K_POLLHI || kind == K_POLLLO) ? OP_POLL_STICKY : kop;
          next_op.data  = kdata;
          next_state    = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (ack_in.done)
        begin
          if (!ack_in.ok && kind != K_RETRY)
          begin
            next_fail  = 1'b1;
            next_state = ST_FINISH;
          end
          else if ((kind == K_POLLHI && !ack_in.sticky) || (kind == K_POLLLO && ack_in.sticky)
                   || (kind == K_RETRY && !(ack_in.ok && ack_in.halted)))
            next_state = ST_ISSUE; // R4 R12 R13
          else
          begin
            next_step  = step + 3'd1;
            next_state = ST_ISSUE;
          end
        end
      end
      ST_PULSE:
      begin
        // the pin must really go low while driven, else the strategy fails
        next_pin_seen = pin_seen || !line_s2;
        if (cnt == CNT_ONE || cnt == CNT_ZERO)
        begin
          next_pin_b = 1'b1;
          next_step  = step + 3'd1;
          if (!(pin_seen || !line_s2))
          begin
            next_fail  = 1'b1; // R7
            next_state = ST_FINISH;
          end
          else
            next_state = ST_ISSUE;
        end
        else
          next_cnt = cnt - CNT_ONE;
      end
      ST_FINISH:
      begin
        next_pin_b = 1'b1;
        next_busy  = 1'b0;
        next_done  = 1'b1;
        next_err   = fail;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      state    <= ST_IDLE;
      step     <= 3'd0;
      fam      <= FAM_LEGACY;
      code     <= 4'h0;
      fail     <= 1'b0;
      cnt      <= CNT_ZERO;
      pin_seen <= 1'b0;
      op       <= '0;
      pin_b    <= 1'b1;
      busy     <= 1'b0;
      done     <= 1'b0;
      err      <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      step     <= next_step;
      fam      <= next_fam;
      code     <= next_code;
      fail     <= next_fail;
      cnt      <= next_cnt;
      pin_seen <= next_pin_seen;
      op       <= next_op;
      pin_b    <= next_pin_b;
      busy     <= next_busy;
      done     <= next_done;
      err      <= next_err;
    end
  end

  assign op_out          = op;
  assign reset_pin_b_out = pin_b;
  assign busy_out        = busy;
  assign done_out        = done;
  assign error_out       = err;

endmodule // drs_sequencer

// ---- verification/drs_sequencer_assertions.sv ----
`timescale 1ns/1ps
module drs_sequencer_assertions
  import drs_pkg::*;
(
  input wire logic     clock_in,
  input wire logic     rst_b_in,
  input wire drs_req_s req_in,
  input wire drs_ack_s ack_in,
  input wire logic     tgt_reset_line_in,
  input wire drs_op_s  op_out,
  input wire logic     reset_pin_b_out,
  input wire logic     busy_out,
  input wire logic     done_out,
  input wire logic     error_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  logic       take;
  logic       mp_take;
  logic       m0;
  logic       next_m0;
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  assign take    = !busy_out && req_in.start;
  assign mp_take = take && req_in.family == FAM_MPROF;
  // latch the default strategy at take; count the current low stretch of the pin
  always_comb
  begin
    next_m0      = take ? mp_take && req_in.code == M_NORMAL : m0;
    next_low_cnt = reset_pin_b_out ? 8'h00 : low_cnt + 8'h01;
  end
  // helpers restart at reset so a cut pulse is never measured
  always_ff @(posedge clock_in)
  begin
    m0      <= rst_b_in ? next_m0 : 1'b0;
    low_cnt <= rst_b_in ? next_low_cnt : 8'h00;
  end
  a_default_catch: assert property (mp_take && req_in.code == M_NORMAL
    |-> ##[1:3] op_out.valid && op_out.op == OP_SET_CATCH) else $error("catch not first");
  a_sys_catch: assert property (op_out.valid && op_out.op == OP_SYS_RESET
    |-> $past(op_out.op) == OP_SET_CATCH) else $error("system reset without catch");
  a_core_catch: assert property (op_out.valid && op_out.op == OP_CORE_RESET
    |-> $past(op_out.op) == OP_SET_CATCH) else $error("core reset without catch");
  a_poll_clear: assert property (op_out.valid && op_out.op == OP_CLR_CATCH && m0
    |-> $past(op_out.op) == OP_POLL_STICKY) else $error("clear before polling");
  a_clear_last: assert property (done_out && m0
    |-> error_out || op_out.op == OP_CLR_CATCH) else $error("clear not last");
  a_bad_done: assert property (mp_take && req_in.code > M_PIN
    |-> ##[1:2] done_out && error_out) else $error("bad code not refused");
  a_bad_quiet: assert property (mp_take && req_in.code > M_PIN
    |=> !op_out.valid [*3]) else $error("op for bad code");
  a_pin_width: assert property ($rose(reset_pin_b_out) && $past(rst_b_in)
    |-> low_cnt == PULSE_CYC) else $error("pin pulse width wrong");
endmodule // drs_sequencer_assertions

bind drs_sequencer drs_sequencer_assertions u_chk (.clock_in, .rst_b_in, .req_in, .ack_in,
  .tgt_reset_line_in, .op_out, .reset_pin_b_out, .busy_out, .done_out, .error_out);

// ---- verification/drs_target_model.sv ----
`timescale 1ns/1ps
module drs_target_model
  import drs_pkg::*;
(
  input  wire logic    clock_in,
  input  wire logic    rst_b_in,
  input  wire drs_op_s op_in,
  input  wire logic    pin_b_in,
  input  wire logic    line_stuck_in,
  input  wire logic    nak_in,
  output drs_ack_s     ack_out,
  output logic         line_out
);
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  logic [2:0] poll_cnt;
  logic [2:0] next_poll_cnt;
  logic       tried;
  logic       next_tried;
  logic       retry_op;
  drs_ack_s   next_ack;
  assign retry_op = op_in.op == OP_WP_HALT || op_in.op == OP_REQ_HALT;
  // answer each op later with one done pulse; sticky reads 0,1,1,0 per reset
  always_comb
  begin
    next_wait_cnt = op_in.valid ? 2'h2 : wait_cnt - {1'b0, wait_cnt != 2'h0};
    next_ack      = '0;
    next_poll_cnt = poll_cnt;
    next_tried    = tried;
    if (wait_cnt == 2'h1)
    begin
      next_ack.done   = 1'b1;
      next_ack.ok     = !nak_in; // applies to retry ops too; use nak only with non-retry ops, a retry would loop
      next_ack.sticky = poll_cnt == 3'h1 || poll_cnt == 3'h2;
      next_ack.halted = !retry_op || tried;
      next_poll_cnt   = op_in.op == OP_POLL_STICKY ? poll_cnt + 3'h1 : 3'h0;
      next_tried      = retry_op && !tried;
    end
  end
  // first halt attempt after a pulse misses, so the retry path is exercised
  always_ff @(posedge clock_in)
  begin
    wait_cnt <= rst_b_in ? next_wait_cnt : 2'h0;
    ack_out  <= rst_b_in ? next_ack : '0;
    poll_cnt <= rst_b_in ? next_poll_cnt : 3'h0;
    tried    <= rst_b_in ? next_tried : 1'b0;
  end
  // reset line has a pull-up; a broken board leaves it high
  assign line_out = pin_b_in | line_stuck_in;
endmodule // drs_target_model

// ---- verification/tb_drs_sequencer.sv ----
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb_drs_sequencer
  import drs_pkg::*;
;
  logic       clock_in;
  logic       rst_b_in;
  logic       stuck;
  logic       nak;
  logic       line;
  drs_req_s   req_in;
  drs_ack_s   ack;
  drs_op_s    op_out;
  logic       reset_pin_b_out;
  logic       busy_out;
  logic       done_out;
  logic       error_out;
  int         errors;
  int         tests_run;
  int         low_tot;
  drs_op_e    ops[$];
  logic [4:0] bad[6] = '{5'h13, 5'h1A, 5'h1F, 5'h00, 5'h07, 5'h0A};

  drs_sequencer DUT (.clock_in, .rst_b_in, .req_in, .ack_in(ack), .tgt_reset_line_in(line),
    .op_out, .reset_pin_b_out, .busy_out, .done_out, .error_out);
  drs_target_model u_tgt (.clock_in, .rst_b_in, .op_in(op_out), .pin_b_in(reset_pin_b_out),
    .line_stuck_in(stuck), .nak_in(nak), .ack_out(ack), .line_out(line));

  always #12.5 clock_in = ~clock_in;

  // trace every issued op and every low cycle of the reset pin
  always @(posedge clock_in)
  begin
    if (op_out.valid === 1'b1)
      ops.push_back(op_out.op);
    if (reset_pin_b_out === 1'b0)
      low_tot++;
  end

  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // n: op count (-1 unknown, -2 last op unknown too); lowc -1 skips the pin
  task automatic run(input logic fam, input logic [3:0] code, input logic err,
                     input int n, input drs_op_e f, input drs_op_e l, input int lowc);
    int i0;
    int l0;
    i0 = ops.size();
    l0 = low_tot;
    req_in <= '{1'b1, fam, code};
    @(posedge clock_in);
    req_in.start <= 1'b0;
    repeat (3000)
    begin
      @(posedge clock_in);
      if (done_out === 1'b1)
        break;
    end
    `CHK("done", 1'b1, done_out)
    `CHK("busy", 1'b0, busy_out)
    `CHK("error", err, error_out)
    if (n >= 0)
      `CHK("op count", n, ops.size() - i0)
    if (n != 0)
      `CHK("first op", f, ops[i0])
    if (n > 0 || n == -1)
      `CHK("last op", l, ops[ops.size() - 1])
    if (lowc >= 0)
      `CHK("pin low", lowc, low_tot - l0)
  endtask

  // a hang is cut short well beyond the longest expected run
  initial
  begin
    repeat (20000) @(posedge clock_in);
    errors++;
    summarize();
  end

  initial
  begin
    clock_in = 1'b0;
    req_in = '0;
    rst_b_in = 1'b0;
    stuck = 1'b0;
    nak = 1'b0;
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    run(FAM_MPROF, M_NORMAL, 1'b0, 7, OP_SET_CATCH, OP_CLR_CATCH, 0);
    run(FAM_MPROF, M_CORE, 1'b0, 7, OP_SET_CATCH, OP_CLR_CATCH, 0);
    run(FAM_MPROF, M_PIN, 1'b0, 2, OP_SET_CATCH, OP_CLR_CATCH, int'(PULSE_CYC));
    stuck <= 1'b1;
    run(FAM_MPROF, M_PIN, 1'b1, 1, OP_SET_CATCH, OP_SET_CATCH, int'(PULSE_CYC));
    stuck <= 1'b0;
    run(FAM_LEGACY, L_HW_BP0, 1'b0, 1, OP_BP_ZERO, OP_BP_ZERO, int'(PULSE_CYC));
    run(FAM_LEGACY, L_SW_ROUT, 1'b0, 4, OP_HALT, OP_RUN_ROUT, 0);
    nak <= 1'b1;
    run(FAM_LEGACY, L_SW_ROUT, 1'b1, 1, OP_HALT, OP_HALT, 0);
    nak <= 1'b0;
    run(FAM_LEGACY, L_NONE, 1'b0, 0, OP_HALT, OP_HALT, 0);
    run(FAM_LEGACY, L_HW_WP, 1'b0, 2, OP_WP_HALT, OP_WP_HALT, int'(PULSE_CYC));
    run(FAM_LEGACY, L_HW_REQ, 1'b0, 2, OP_REQ_HALT, OP_REQ_HALT, int'(PULSE_CYC));
    run(FAM_LEGACY, L_SW_REGS, 1'b0, 1, OP_LOAD_REGS, OP_LOAD_REGS, 0);
    `CHK("regs data", {CURRENT_PROGRAM_STATUS_RESET_VAL[15:0], SAVED_PROGRAM_STATUS_RESET_VAL[15:0]}, op_out.data)
    run(FAM_LEGACY, L_PERIPH, 1'b0, 1, OP_RSTC_WRITE, OP_RSTC_WRITE, 0);
    `CHK("rstc data", RSTC_CMD_VAL, op_out.data)
    run(FAM_LEGACY, L_REMAP, 1'b0, 2, OP_BP_ZERO, OP_MAP_FLASH, int'(PULSE_CYC));
    foreach (bad[i])
      run(bad[i][4], bad[i][3:0], 1'b1, 0, OP_HALT, OP_HALT, 0);
    summarize();
  end
endmodule // tb_drs_sequencer
